// ==== core/adc_readout.sv ====
// readout control of a 24-bit converter: sequencing and serial word
// ------------------------------------------------------------------
// Overview of operation
// - chip select low wakes and enables data output
// - sleep after conversion while chip select high
// - chip select rise puts data output high-z
// - chip select rise mid-word aborts, restarts conversion
// - data output shows status while select is low, converting or done; high-z while sleeping
// - clock pin direction from level at boot/select fall
// - internal clock mode enables clock pin pull-up
// - tied f0 picks 50 or 60 hz timing
// - toggling f0 clocks conversion, null f/2560
// - word is status, 24-bit result, sub bits
// - bit 31 high converting, low when done
// - bit 30 tells which channel was converted
// - bit 29 is sign, positive at zero
// - bit 28 flags input outside zero..reference
// - bits 27..4 result, 3..0 sub bits
// - clock pulses ignored while chip select high
// - status level follows conversion live before shifting
// - bit 30 leaves on first falling edge
// - bit 0 leaves on 31st falling edge
// - 32nd fall drives high, starts conversion
// - out-of-range inputs clamp to limit codes
// - two-channel variant alternates channel every conversion
// - first conversion after reset uses channel a
// ------------------------------------------------------------------
`timescale 1ns/1ps

// ------------------------------------------------------------------
// two-entry word buffer between converter and shifter
// ------------------------------------------------------------------
module word_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  input wire logic i_out_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH]; // word storage, no reset needed
  logic [AW-1:0] wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr; // oldest word
  logic [AW:0] count; // words held
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage write
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // word_buffer

// ------------------------------------------------------------------
// top: conversion sequencing and serial readout
// ------------------------------------------------------------------
module adc_readout #(
  parameter int P_CONV_CYC_50 = adc_pkg::CONV_CYC_50,
  parameter int P_CONV_CYC_60 = adc_pkg::CONV_CYC_60,
  parameter int P_EXT_CONV_EDGES = adc_pkg::EXT_CONV_EDGES,
  parameter int P_EXT_IDLE_CYC = adc_pkg::EXT_IDLE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_f0,
  input wire logic i_two_channel,
  input wire logic signed [31:0] i_raw_result,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_sck_pullup_en,
  output logic o_sleep,
  output logic o_channel_b
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adc_pkg::pins_s pin_meta; // first sync stage, read only by pin_s
  adc_pkg::pins_s pin_s; // synchronised pins
  adc_pkg::pins_s pin_d; // one cycle older, for edges
  adc_pkg::conv_state_e state; // converter sequencing
  adc_pkg::word_s word_q; // last formatted result
  adc_pkg::word_s head; // word at buffer output
  logic [31:0] head_bits;
  logic cs_s, cs_fall, cs_rise, sck_s;
  logic f0_rise, f0_edge;
  logic [1:0] boot_cnt; // power-up strap sampling delay
  logic int_mode; // internal serial clock mode
  logic ext_osc; // f0 is toggling as conversion clock
  logic [16:0] idle_cnt; // cycles since last f0 edge
  logic [1:0] f0_div; // f0 edge divider for serial clock
  logic [23:0] conv_cnt; // conversion progress
  logic [23:0] conv_last;
  logic conv_step, conv_done;
  logic chan; // channel being converted
  logic buf_push, buf_ready, buf_valid;
  logic [11:0] half_cnt; // internal clock half period
  logic isck_run, isck_tick;
  logic sck_fall, sck_rise_ext, sck_fall_ext;
  logic [5:0] bit_cnt; // falling edges seen this readout
  logic [5:0] bit_nxt;
  logic fall_last, abort, pop, eoc;

  // result formatting with range clamp
  function automatic adc_pkg::word_s fmt(
    input logic signed [31:0] raw,
    input logic ch
  );
    logic signed [31:0] c;
    adc_pkg::word_s w;
    c = raw;
    if (raw > adc_pkg::RAW_CLAMP_HI) begin
      c = adc_pkg::RAW_CLAMP_HI;
    end else if (raw < adc_pkg::RAW_CLAMP_LO) begin
      c = adc_pkg::RAW_CLAMP_LO;
    end
    w.eoc = 1'b0;
    w.channel = ch;
    w.sign = (c >= adc_pkg::RAW_ZERO);
    w.out_of_range_flag = (c < adc_pkg::RAW_ZERO) ||
      (c > adc_pkg::RAW_FULL_SCALE);
    {w.data, w.sub} = c[adc_pkg::CODE_BITS-1:0];
    return w;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  // all pins come from outside, two flops before use
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= adc_pkg::PIN_IDLE;
      pin_s <= adc_pkg::PIN_IDLE;
      pin_d <= adc_pkg::PIN_IDLE;
    end else begin
      pin_meta <= {i_two_channel, i_f0, i_sck, i_cs_n};
      pin_s <= pin_meta;
      pin_d <= pin_s;
    end
  end

  assign cs_s = pin_s.cs_n;
  assign sck_s = pin_s.sck;
  assign cs_fall = pin_d.cs_n && !pin_s.cs_n;
  assign cs_rise = !pin_d.cs_n && pin_s.cs_n;
  assign f0_rise = !pin_d.f0 && pin_s.f0;
  assign f0_edge = pin_d.f0 ^ pin_s.f0;
  assign sck_rise_ext = !pin_d.sck && pin_s.sck;
  assign sck_fall_ext = pin_d.sck && !pin_s.sck;

  // ----------------------------------------------------------------
  // serial clock mode
  // ----------------------------------------------------------------
  // the strap is caught once sync flops hold the real pin level
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_cnt <= '0;
    end else if (boot_cnt != adc_pkg::BOOT_DONE) begin
      boot_cnt <= boot_cnt + 1'b1;
    end
  end

  // high clock pin at boot or select fall means internal clock
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_mode <= 1'b1;
    end else if (boot_cnt == adc_pkg::BOOT_SAMPLE || cs_fall) begin
      int_mode <= sck_s;
    end
  end

  // ----------------------------------------------------------------
  // conversion clock source
  // ----------------------------------------------------------------
  // a quiet f0 is a tied level; any edge marks an external clock
  // edges are ignored until the sync flops hold real pin levels, so a
  // pin tied high does not look like a clock edge just after reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_osc <= 1'b0;
      idle_cnt <= '0;
    end else if (f0_edge && boot_cnt == adc_pkg::BOOT_DONE) begin
      ext_osc <= 1'b1;
      idle_cnt <= '0;
    end else if (idle_cnt == 17'(P_EXT_IDLE_CYC - 1)) begin
      ext_osc <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // divides f0 so the serial clock runs at an eighth of it
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      f0_div <= '0;
    end else if (f0_rise) begin
      f0_div <= f0_div + 1'b1;
    end
  end

  // conversion length: f0 edges, else system cycles per null
  assign conv_last = ext_osc ? 24'(P_EXT_CONV_EDGES - 1) :
    (pin_s.f0 ? 24'(P_CONV_CYC_50 - 1) :
    24'(P_CONV_CYC_60 - 1));
  assign conv_step = ext_osc ? f0_rise : 1'b1;
  // at or past the limit: a source switch mid-conversion may shorten
  // the limit below the count, which must not run the counter around
  assign conv_done = (state == adc_pkg::ST_CONVERT) && conv_step &&
    (conv_cnt >= conv_last);

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  // push waits while the buffer is full, stalling the next conversion
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= adc_pkg::ST_CONVERT;
      word_q <= '0;
    end else begin
      case (state)
        adc_pkg::ST_CONVERT: begin
          if (conv_done) begin
            word_q <= fmt(i_raw_result, chan);
            state <= adc_pkg::ST_PUSH;
          end
        end
        adc_pkg::ST_PUSH: begin
          if (buf_ready) begin
            state <= adc_pkg::ST_READY;
          end
        end
        adc_pkg::ST_READY: begin
          // result held until read out or aborted
          if (pop) begin
            state <= adc_pkg::ST_CONVERT;
          end
        end
        default: begin
          state <= adc_pkg::ST_CONVERT;
        end
      endcase
    end
  end

  // conversion progress counter
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_cnt <= '0;
    end else if (state != adc_pkg::ST_CONVERT || conv_done) begin
      conv_cnt <= '0;
    end else if (conv_step) begin
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  // channel alternation, channel a first after reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan <= 1'b0;
    end else if (buf_push && pin_s.two_ch) begin
      chan <= !chan;
    end
  end

  assign buf_push = (state == adc_pkg::ST_PUSH) && buf_ready;
  assign eoc = (state != adc_pkg::ST_READY);

  word_buffer #(
    .WIDTH(adc_pkg::WORD_BITS),
    .DEPTH(2)
  ) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_in_valid(state == adc_pkg::ST_PUSH),
    .i_in_data(word_q),
    .o_in_ready(buf_ready),
    .i_out_ready(pop),
    .o_out_valid(buf_valid),
    .o_out_data(head_bits)
  );
  assign head = head_bits;

  // ----------------------------------------------------------------
  // internal serial clock
  // ----------------------------------------------------------------
  assign isck_run = int_mode && !cs_s && buf_valid &&
    (state == adc_pkg::ST_READY) && (bit_cnt != adc_pkg::LAST_FALL);
  assign isck_tick = ext_osc ?
    (f0_rise && f0_div == adc_pkg::EXT_SCK_DIV) :
    (half_cnt == 12'(adc_pkg::ISCK_HALF_CYC - 1));

  // half period timer, idle outside a readout
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_cnt <= '0;
    end else if (!isck_run || isck_tick) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // clock level; low when idle so 32 falls give 32 pulses
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sck <= 1'b0;
    end else if (!isck_run) begin
      o_sck <= 1'b0;
    end else if (isck_tick) begin
      o_sck <= !o_sck;
    end
  end

  // pin direction and pull-up follow the sampled mode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sck_oe <= 1'b0;
      o_sck_pullup_en <= 1'b0;
    end else begin
      o_sck_oe <= int_mode && !cs_s;
      o_sck_pullup_en <= int_mode;
    end
  end

  // ----------------------------------------------------------------
  // output shifter
  // ----------------------------------------------------------------
  // external edges only count with select low and a result held
  assign sck_fall = int_mode ? (isck_run && isck_tick && o_sck) :
    (sck_fall_ext && !cs_s && buf_valid &&
    state == adc_pkg::ST_READY);
  assign bit_nxt = bit_cnt + 1'b1;
  assign fall_last = sck_fall &&
    (bit_nxt == adc_pkg::LAST_FALL);
  assign abort = cs_rise && (bit_cnt != '0) &&
    (state == adc_pkg::ST_READY);
  assign pop = (state == adc_pkg::ST_READY) && (fall_last || abort);

  // bit pointer, frozen while select is high
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt <= '0;
    end else if (cs_fall || pop) begin
      bit_cnt <= '0;
    end else if (sck_fall) begin
      bit_cnt <= bit_nxt;
    end
  end

  // data pin: live status until shifting, then word bits on falls
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sdo <= 1'b1;
    end else if (cs_s) begin
      o_sdo <= 1'b1;
    end else if (fall_last) begin
      o_sdo <= 1'b1;
    end else if (sck_fall) begin
      o_sdo <= head_bits[5'(adc_pkg::WORD_MSB - bit_nxt)];
    end else if (bit_cnt == '0) begin
      o_sdo <= eoc;
    end
  end

  // driver enable and sleep indication
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sdo_oe <= 1'b0;
      o_sleep <= 1'b0;
      o_channel_b <= 1'b0;
    end else begin
      o_sdo_oe <= !cs_s;
      o_sleep <= cs_s && (state == adc_pkg::ST_READY);
      o_channel_b <= chan;
    end
  end

  // ----------------------------------------------------------------
  // assertions and helper logic
  // ----------------------------------------------------------------
  logic [5:0] rise_cnt; // internal rises this readout
  logic first_seen; // a result was already pushed
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rise_cnt <= '0;
      first_seen <= 1'b0;
    end else begin
      if (cs_fall || pop) begin
        rise_cnt <= '0;
      end else if (isck_run && isck_tick && !o_sck) begin
        rise_cnt <= rise_cnt + 1'b1;
      end
      if (buf_push) begin
        first_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sdo_enable_a: assert property ($fell(cs_s) |=> o_sdo_oe)
    else $error("data output not enabled after select fall");
  sdo_release_a: assert property (cs_s |=> !o_sdo_oe)
    else $error("data output driven while select high");
  sleep_hold_a: assert property (
    (cs_s && state == adc_pkg::ST_READY) [*2] |-> o_sleep)
    else $error("not asleep with select high after conversion");
  abort_restart_a: assert property (
    abort |=> state == adc_pkg::ST_CONVERT && conv_cnt == '0)
    else $error("abort did not restart conversion");
  eoc_live_a: assert property (
    (!cs_s && bit_cnt == '0 && !sck_fall && !pop) |=>
    o_sdo == $past(eoc))
    else $error("status bit does not follow converter");
  first_bit_a: assert property (
    (sck_fall && bit_cnt == '0) |=> o_sdo == head.channel)
    else $error("channel bit not on first falling edge");
  last_fall_a: assert property (
    fall_last |=> o_sdo && state == adc_pkg::ST_CONVERT)
    else $error("32nd fall did not start conversion");
  pulse_count_a: assert property (
    rise_cnt <= adc_pkg::LAST_FALL)
    else $error("more than 32 internal clock pulses");
  pointer_hold_a: assert property (
    (cs_s && !cs_rise) |=> $stable(bit_cnt))
    else $error("bit pointer moved with select high");
  mode_sample_a: assert property (
    cs_fall |=> int_mode == $past(sck_s))
    else $error("clock mode not sampled at select fall");
  clamp_hi_a: assert property (
    (conv_done && i_raw_result > adc_pkg::RAW_CLAMP_HI) |=>
    word_q == fmt(adc_pkg::RAW_CLAMP_HI, chan))
    else $error("high input not clamped");
  chan_alt_a: assert property (
    (buf_push && pin_s.two_ch) |=> chan != $past(chan))
    else $error("channel did not alternate");
  first_chan_a: assert property (
    (buf_push && !first_seen) |-> !word_q.channel)
    else $error("first conversion not on channel a");
  pullup_a: assert property (o_sck_oe |-> o_sck_pullup_en)
    else $error("pull-up off while driving clock");

  full_read_c: cover property (fall_last);
  abort_c: cover property (abort);
  ext_osc_c: cover property (ext_osc && conv_done);
  chan_b_c: cover property (buf_push && word_q.channel);
endmodule // adc_readout

// ==== include/adc_pkg.sv ====
// shared constants and types for the converter readout control
package adc_pkg;
  // ----------------------------------------------------------------
  // clock rate and conversion timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 100; // system clock, 10 ns period
  localparam int CONV_TIME_50_US = 160000; // 50 hz null conversion
  localparam int CONV_TIME_60_US = 133333; // 60 hz null conversion
  localparam int CONV_CYC_50 = CONV_TIME_50_US * SYS_CLK_MHZ;
  localparam int CONV_CYC_60 = CONV_TIME_60_US * SYS_CLK_MHZ;
  localparam int NULL_DIV = 2560; // conversion clocks per null period
  localparam int NULLS_PER_CONV = 8; // null periods per conversion
  localparam int EXT_CONV_EDGES = NULL_DIV * NULLS_PER_CONV;
  localparam int EXT_IDLE_US = 1000; // f0 quiet this long: pin is tied
  localparam int EXT_IDLE_CYC = EXT_IDLE_US * SYS_CLK_MHZ;
  localparam int ISCK_FREQ_HZ = 19200; // internal serial clock rate
  localparam int ISCK_HALF_CYC =
    (SYS_CLK_MHZ * 1000000) / (2 * ISCK_FREQ_HZ);
  localparam logic [1:0] EXT_SCK_DIV = 2'h3; // half period: 4 f0 rises
  localparam logic [1:0] BOOT_SAMPLE = 2'h2; // strap sampled here
  localparam logic [1:0] BOOT_DONE = 2'h3;
  // ----------------------------------------------------------------
  // output word layout and result coding
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam int CODE_BITS = 28; // 24 result bits plus 4 sub bits
  localparam logic [5:0] LAST_FALL = 6'h20; // falls per readout
  localparam logic [5:0] WORD_MSB = 6'h1f;
  localparam logic signed [31:0] RAW_ZERO = 32'sh0;
  localparam logic signed [31:0] RAW_FULL_SCALE = 32'sh0fffffff;
  localparam logic signed [31:0] RAW_CLAMP_HI = 32'sh11ffffff;
  localparam logic signed [31:0] RAW_CLAMP_LO = 32'shfe000000;
  typedef struct packed {
    logic eoc; // high while converting
    logic channel; // low: channel a, high: channel b
    logic sign; // high for zero or positive input
    logic out_of_range_flag; // high outside zero..reference
    logic [23:0] data; // result, msb first
    logic [3:0] sub; // sub lsb bits
  } word_s;
  typedef struct packed {
    logic two_ch; // two-channel variant strap
    logic f0; // frequency_control_pin
    logic sck; // serial clock pin level
    logic cs_n; // chip select, active low
  } pins_s;
  localparam pins_s PIN_IDLE = 4'h3; // cs and sck high, rest low
  typedef enum logic [2:0] {
    ST_CONVERT = 3'b001,
    ST_PUSH = 3'b010,
    ST_READY = 3'b100
  } conv_state_e;
endpackage

// ==== verif/host_model.sv ====
// host model: serial master that reads the converter word
`timescale 1ns/1ps

module host_model (
  input wire logic i_sys_clk,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sck
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  // clock held low so the strap reads external mode unless the bench drives it high
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
  end

  // ------------------------------------------------------------
  // one transfer; sel low pulses the clock with select high
  // ------------------------------------------------------------
  // phases are five cycles: the pins pass two sync flops inside
  task automatic xfer(input bit sel, input int falls,
      output logic [31:0] w, output logic [1:0] st, output int wt);
    w = 32'h0;
    if (sel) o_cs_n <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    st[1] = i_sdo;
    wt = 5;
    // bounded poll for the end-of-conversion level
    while (sel && i_sdo !== 1'b0 && wt < 3000) begin
      @(posedge i_sys_clk);
      wt++;
    end
    // sample just before each rise, then fall
    for (int b = 31; b > 31 - falls; b--) begin
      w[b] = i_sdo;
      o_sck <= 1'b1;
      repeat (5) @(posedge i_sys_clk);
      o_sck <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
    end
    st[0] = i_sdo;
    o_cs_n <= 1'b1;
    @(posedge i_sys_clk);
  endtask
endmodule // host_model

// ==== verif/adc_readout_test.sv ====
// self-checking bench for the converter readout control
`timescale 1ns/1ps

module adc_readout_test;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_f0 = 1'b0;
  logic i_two_channel = 1'b1;
  logic signed [31:0] raw = 32'sh0;
  wire logic cs_n, sck, sdo_pin;
  logic o_sdo, o_sdo_oe, o_sck, o_sck_oe, o_sck_pullup_en;
  logic o_sleep, o_channel_b;
  logic [31:0] w;
  logic [1:0] st;
  int wt;
  int fail_count = 0;
  int compares = 0;
  logic f0_run = 1'b0; // toggles f0 as an external clock
  int f0_cnt = 0;
  int sck_rises = 0; // rises of the design-driven serial clock
  typedef struct {logic signed [31:0] raw; logic [31:0] word;} row_s;
  row_s rows [7] = '{'{32'sh0, 32'h20000000},
    '{32'sh0fffffff, 32'h2fffffff}, '{32'sh10000000, 32'h30000000},
    '{32'sh7fffffff, 32'h31ffffff}, '{-32'sh1, 32'h1fffffff},
    '{32'sh80000000, 32'h1e000000}, '{32'sh07654321, 32'h27654321}};

  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge o_sck) sck_rises++;
  // released line shows the inverse, never a stale level
  assign sdo_pin = o_sdo_oe ? o_sdo : ~o_sdo;

  // ------------------------------------------------------------
  // design and host; counts shortened for simulation
  // ------------------------------------------------------------
  adc_readout #(.P_CONV_CYC_50(200), .P_CONV_CYC_60(150),
    .P_EXT_CONV_EDGES(20), .P_EXT_IDLE_CYC(50)) i_adc_readout (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
    .i_sck(sck), .i_f0(i_f0), .i_two_channel(i_two_channel),
    .i_raw_result(raw), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_sck(o_sck), .o_sck_oe(o_sck_oe),
    .o_sck_pullup_en(o_sck_pullup_en), .o_sleep(o_sleep),
    .o_channel_b(o_channel_b));
  host_model i_host_model (.i_sys_clk(i_sys_clk), .i_sdo(sdo_pin),
    .o_cs_n(cs_n), .o_sck(sck));

  // external conversion clock: half period of ten cycles
  always @(posedge i_sys_clk) begin
    if (f0_run) begin
      f0_cnt <= f0_cnt + 1;
      if (f0_cnt % 10 == 9) i_f0 <= ~i_f0;
    end
  end

  // ------------------------------------------------------------
  // comparison and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] inr(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  task automatic wrap_up();
    $display("fails %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // guard against a hang; the run needs about 14k cycles
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    fail_count++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    // table rows: one readout each, channel alternates per row
    for (int i = 0; i < 7; i++) begin
      raw <= rows[i].raw;
      i_host_model.xfer(1'b1, 32, w, st, wt);
      check(w, rows[i].word | {1'b0, i[0], 30'h0});
      check({30'h0, st}, 32'h3);
      check(o_channel_b, {31'h0, ~i[0]});
      if (i > 0) check(inr(wt, 140, 165), 32'h1);
      repeat (4) @(posedge i_sys_clk);
      check(o_sdo_oe, 32'h0);
    end
    raw <= 32'sh0abcdef0;
    // sleeps once the result is held with select high
    repeat (200) @(posedge i_sys_clk);
    check(o_sleep, 32'h1);
    // clock pulses with select high, then a select without falls
    i_host_model.xfer(1'b0, 32, w, st, wt);
    i_host_model.xfer(1'b1, 0, w, st, wt);
    check({30'h0, st}, 32'h0);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check(w, 32'h6abcdef0);
    // abort after five falls restarts the conversion
    i_host_model.xfer(1'b1, 5, w, st, wt);
    check({27'h0, w[31:27]}, 32'h5);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check({31'h0, st[1]}, 32'h1);
    check(inr(wt, 140, 165), 32'h1);
    check(w, 32'h6abcdef0);
    // f0 tied high: longer conversion
    repeat (300) @(posedge i_sys_clk);
    i_f0 <= 1'b1;
    repeat (60) @(posedge i_sys_clk);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check(inr(wt, 190, 215), 32'h1);
    // f0 toggling: twenty rises of twenty cycles each
    f0_run <= 1'b1;
    i_host_model.xfer(1'b1, 32, w, st, wt);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check(inr(wt, 370, 430), 32'h1);
    // second resets: strap high then low, one channel at the end
    for (int m = 1; m >= 0; m--) begin
      i_nrst <= 1'b0;
      f0_run <= m[0]; // f0 paces the internal clock in the first pass
      i_host_model.o_sck <= m[0];
      i_two_channel <= m[0];
      repeat (3) @(posedge i_sys_clk);
      check({o_sdo_oe, o_sleep, o_channel_b}, 32'h0);
      i_nrst <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      check(o_sck_pullup_en, {31'h0, m[0]});
      check(o_sck_oe, 32'h0);
      if (m == 1) begin
        // internal clock: data sampled on the design's own rises
        i_host_model.o_cs_n <= 1'b0;
        for (int b = 31; b >= 0; b--) begin
          @(posedge o_sck);
          w[b] = sdo_pin;
        end
        repeat (200) @(posedge i_sys_clk);
        check(w, 32'h2abcdef0);
        check(sck_rises, 32'h20);
        check({o_sck_oe, o_sck_pullup_en, o_sck}, 32'h6);
        i_host_model.o_cs_n <= 1'b1;
      end
    end
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check(w[30], 32'h0);
    i_host_model.xfer(1'b1, 32, w, st, wt);
    check(w[30], 32'h0);
    wrap_up();
  end
endmodule // adc_readout_test
